// [core/edge_capture_pkg.sv]
// Constants for the edge-triggered capture module
package edge_capture_pkg;
  localparam int COUNT_WIDTH = 16;
  localparam int BYTE_WIDTH = 8;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [1:0] SYNC_RESET = 2'b00;
  localparam int SYNC_STAGES = 2;
endpackage

// [core/pin_sync.sv]
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ps
module pin_sync
  import edge_capture_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_async,
  output logic pin_level,
  output logic pin_rise,
  output logic pin_fall
);
  logic stage1;
  logic stage2;
  logic stage3;

  // Stage1 feeds only stage2 to keep metastability contained
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1 <= SYNC_RESET[0];
      stage2 <= SYNC_RESET[0];
      stage3 <= SYNC_RESET[0];
    end else begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign pin_level = stage2;
  assign pin_rise = stage2 & ~stage3;
  assign pin_fall = ~stage2 & stage3;
endmodule // pin_sync

// [core/edge_capture_module.sv]
// Edge-triggered capture module of the counter array
//
// Operation
// - Valid pin edge copies counter into capture
// - Two select bits choose rising, falling, both
// - Each capture sets the capture flag
// - Set flag with enable raises interrupt request
// - Flag stays set until software clears it
// - Pin level stays readable when both selected
`timescale 1ns/1ps
module edge_capture_module
  import edge_capture_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic capture_input_pin,
  input wire logic [COUNT_WIDTH-1:0] counter_value,
  input wire logic rise_edge_select,
  input wire logic fall_edge_select,
  input wire logic flag_int_enable,
  input wire logic flag_clear,
  output logic [BYTE_WIDTH-1:0] capture_value_low,
  output logic [BYTE_WIDTH-1:0] capture_value_high,
  output logic capture_compare_flag,
  output logic interrupt_request,
  output logic port_pin_level
);
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic [COUNT_WIDTH-1:0] capture_reg;
  logic next_flag;
  wire capture_event;

  pin_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_async(capture_input_pin),
    .pin_level(pin_level),
    .pin_rise(pin_rise),
    .pin_fall(pin_fall)
  );

  assign capture_event = (rise_edge_select & pin_rise) | (fall_edge_select & pin_fall);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      capture_reg <= CAPTURE_RESET;
    end else if (capture_event) begin
      capture_reg <= counter_value;
    end
  end

  // Set beats clear so a capture in the clearing cycle is not lost
  assign next_flag = capture_event | (capture_compare_flag & ~flag_clear);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      capture_compare_flag <= FLAG_RESET;
    end else begin
      capture_compare_flag <= next_flag;
    end
  end

  assign capture_value_low = capture_reg[BYTE_WIDTH-1:0];
  assign capture_value_high = capture_reg[COUNT_WIDTH-1:BYTE_WIDTH];
  assign interrupt_request = capture_compare_flag & flag_int_enable;
  // Always visible, so software can tell the edge in either-edge mode
  assign port_pin_level = pin_level;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_CAPTURE_LOADS: assert property (capture_event |=>
      {capture_value_high, capture_value_low} == $past(counter_value))
    else $error("capture did not load counter");
  AST_HOLD_NO_EVENT: assert property (!capture_event |=> $stable(capture_reg))
    else $error("capture changed without event");
  AST_RISE_ONLY: assert property ((pin_rise && !rise_edge_select) |-> !capture_event)
    else $error("rise captured while disabled");
  AST_FALL_CAPTURE: assert property ((pin_fall && fall_edge_select) |-> capture_event)
    else $error("fall not captured");
  AST_FLAG_SET: assert property (capture_event |=> capture_compare_flag)
    else $error("flag not set on capture");
  AST_IRQ: assert property ((capture_compare_flag && flag_int_enable) |-> interrupt_request)
    else $error("interrupt missing");
  AST_FLAG_STICKY: assert property ((capture_compare_flag && !flag_clear) |=>
      capture_compare_flag)
    else $error("flag dropped without clear");
  // Reset must have been off for the whole synchroniser depth, else stages hold reset values
  AST_PIN_LEVEL: assert property ((rise_edge_select && fall_edge_select && $past(rst_n)
      && $past(rst_n, 2)) |-> port_pin_level == $past(capture_input_pin, 2))
    else $error("pin level not readable");
  AST_ONE_CAPTURE: assert property (capture_event |=> !capture_event)
    else $error("double capture per transition");
  AST_EDGE_FROM_PIN: assert property ((capture_event && $past(rst_n) && $past(rst_n, 2)
      && $past(rst_n, 3)) |-> $past(capture_input_pin, 2) != $past(capture_input_pin, 3))
    else $error("capture without pin transition");
  AST_NO_BOTH_EDGES: assert property (!(pin_rise && pin_fall))
    else $error("rise and fall flagged together");
  AST_RISE_CAPTURE: assert property ((pin_rise && rise_edge_select) |-> capture_event)
    else $error("rise not captured");
  AST_NONE_SELECTED: assert property ((!rise_edge_select && !fall_edge_select) |->
      !capture_event)
    else $error("capture with no edge selected");
  AST_FLAG_CLEAR: assert property ((flag_clear && !capture_event) |=>
      !capture_compare_flag)
    else $error("flag not cleared");
  AST_FLAG_ONLY_BY_CAPTURE: assert property ((!capture_compare_flag && !capture_event) |=>
      !capture_compare_flag)
    else $error("flag set without capture");
  AST_IRQ_MASKED: assert property (!flag_int_enable |-> !interrupt_request)
    else $error("interrupt while disabled");

  COV_RISE: cover property (rise_edge_select && pin_rise);
  COV_FALL: cover property (fall_edge_select && pin_fall);
  COV_CLEAR_SET: cover property (flag_clear && capture_event);
  COV_IRQ: cover property ($rose(interrupt_request));
endmodule // edge_capture_module

// [dv/pin_source.sv]
// Source model driving the capture pin
`timescale 1ns/1ps
module pin_source (
  input wire logic core_clk,
  input wire logic want_level,
  output logic capture_input_pin
);
  // Moves just after an edge, so each level lasts whole cycles
  initial capture_input_pin = 1'b0;
  always @(posedge core_clk) capture_input_pin <= #2 want_level;
endmodule // pin_source

// [dv/edge_capture_module_tb.sv]
// Self-checking bench for the edge capture module
`timescale 1ns/1ps
module edge_capture_module_tb;
  import edge_capture_pkg::*;
  logic core_clk, rst_n = 1'b0, pin_want = 1'b0, rise = 1'b0, fall = 1'b0;
  logic pin, en = 1'b0, clr = 1'b0, flag, irq, lvl;
  logic [15:0] cnt = 16'h0000, exp_cap = 16'h0000;
  logic [7:0] lo, hi;
  int n_errors = 0, n_compared = 0;
  // Rows: rise, fall, new pin level, capture expected
  logic [3:0] rows [7] = '{4'hB, 4'h8, 4'h6, 4'h5, 4'hF, 4'hD, 4'h2};
  pin_source u_pin_source (.core_clk(core_clk), .want_level(pin_want), .capture_input_pin(pin));
  edge_capture_module u_edge_capture_module (.core_clk(core_clk), .rst_n(rst_n),
    .capture_input_pin(pin), .counter_value(cnt), .rise_edge_select(rise),
    .fall_edge_select(fall), .flag_int_enable(en), .flag_clear(clr),
    .capture_value_low(lo), .capture_value_high(hi), .capture_compare_flag(flag),
    .interrupt_request(irq), .port_pin_level(lvl));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    step(4);
    rst_n = 1'b1;
    check("cap", {hi, lo}, 16'h0000);
    check("flag", 16'(flag), 16'h0000);
    foreach (rows[i]) begin
      {rise, fall} = rows[i][3:2];
      en = i[0];
      cnt = 16'h1111 * 16'(i + 1);
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      pin_want = rows[i][1];
      step(5);
      if (rows[i][0]) exp_cap = cnt;
      check("cap", {hi, lo}, exp_cap);
      check("flag", 16'(flag), 16'(rows[i][0]));
      check("irq", 16'(irq), 16'(rows[i][0] & en));
      check("level", 16'(lvl), 16'(pin_want));
    end
    // Counter moves after the edge: a second capture would show it
    cnt = 16'h3E7D;
    {rise, fall} = 2'b11;
    pin_want = 1'b0;
    step(5);
    cnt = 16'hFFFF;
    step(20);
    check("cap", {hi, lo}, 16'h3E7D);
    check("flag", 16'(flag), 16'h0001);
    clr = 1'b1;
    step(1);
    check("flag", 16'(flag), 16'h0000);
    // Clear held across a capture: the set must win
    pin_want = 1'b1;
    step(4);
    check("cap", {hi, lo}, 16'hFFFF);
    check("flag", 16'(flag), 16'h0001);
    step(1);
    clr = 1'b0;
    check("flag", 16'(flag), 16'h0000);
    rst_n = 1'b0;
    step(1);
    check("cap", {hi, lo}, 16'h0000);
    finish_test();
  end
  initial begin
    step(400);
    n_errors++;
    finish_test();
  end
endmodule // edge_capture_module_tb
